// ---- pin_mux_pkg.sv ----
// Constants for the multifunction status pin selector
package pin_mux_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_FUNC = 12'h000;
    localparam logic [11:0] ADDR_PIN_STAT = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
    // Reset values
    localparam logic [7:0] FUNC_RST = 8'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // Function code layout
    localparam int DIR_BIT = 7;
    localparam logic [1:0] LOOP_GROUP = 2'h3;
    // Sub codes within one loop group
    localparam int SUB_PHASE_LOCK = 0;
    localparam int SUB_FREQ_LOCK = 1;
    localparam int SUB_ALOOP_LOCK = 2;
    localparam int SUB_ALOOP_CAL = 3;
    localparam int SUB_ACTIVE = 4;
    localparam int SUB_FREE_RUN = 5;
    localparam int SUB_HOLDOVER = 6;
    localparam int SUB_SWITCH = 7;
    localparam int SUB_HIST_AVAIL = 8;
    localparam int SUB_HIST_UPD = 9;
    localparam int SUB_CLAMP = 10;
    localparam int SUB_SLEW = 11;
    localparam int SUB_SYNC = 12;
    localparam int SUB_DEMAP = 13;
    // Bit positions inside the mirrored status bytes
    localparam int LOCK_PHASE_BIT = 1;
    localparam int LOCK_FREQ_BIT = 2;
    localparam int ALOOP_LOCK_BIT = 3;
    localparam int ALOOP_CAL_BIT = 4;
    localparam int ACTIVE_BASE_BIT = 4;
    localparam int FREE_RUN_BIT = 0;
    localparam int HOLDOVER_BIT = 1;
    localparam int SWITCH_BIT = 2;
    localparam int HIST_AVAIL_BIT = 0;
    localparam int CLAMP_BIT = 1;
    localparam int SLEW_BIT = 2;
    localparam int DEMAP_BIT = 3;
    localparam int DEMAP_BIT_LOOP2 = 4;
    localparam int HIST_EVT_BIT = 4;
    // Interrupt status layout
    localparam int IRQ_W = 3;
    localparam int IRQ_OUT_RISE = 0;
    localparam int IRQ_OUT_FALL = 1;
    localparam int IRQ_IN_EDGE = 2;
endpackage

// ---- status_pin_output_select.sv ----
// Multifunction pin selector with APB registers and interrupt
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
// Contract
// - Direction bit clear: pin is an input
// - Direction bit set: pin drives selected status
// - Codes D0/E0/F0 give phase lock
// - Codes D1/E1/F1 give frequency lock
// - Codes D2/E2/F2 give analog loop lock
// - Codes D3/E3/F3 give analog calibration busy
// - Codes D4/E4/F4 OR reference active bits
// - Codes D5/E5/F5 give free run state
// - Codes D6/E6/F6 give holdover state
// - Codes D7/E7/F7 give switchover state
// - Codes D8/E8/F8 give history available
// - Codes D9/E9/F9 mirror history update event
// - Codes CA..FA give clamp flag
// - Codes CB..FB give phase slew limited
// - Codes CC..FC give distribution sync pulse
// - Codes CD..FD give demapping clamp flag
module status_pin_output_select
    import pin_mux_pkg::*;
#(
    parameter int LOOPS = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Mirrored status: one byte per loop or reference, two shared event bytes, one sync bit per loop
    input wire logic [31:0] ref_status_i,
    input wire logic [31:0] loop_lock_i,
    input wire logic [31:0] loop_state_i,
    input wire logic [31:0] loop_hist_i,
    input wire logic [7:0] event_0c_i,
    input wire logic [7:0] event_0f_i,
    input wire logic [3:0] dist_sync_i,
    // Multifunction pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    // Input function hand-off
    output logic [6:0] input_func_o,
    output logic input_level_o,
    // Interrupt
    output logic irq_o
);

    logic [7:0] func_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;
    logic out_d_r;
    logic in_d_r;
    logic lvl_vld_r;
    logic prev_vld_r;
    logic sel_nxt;
    logic [15:0] loop_sig [LOOPS];
    logic wr_en;
    logic addr_ok;
    logic [31:0] rd_nxt;

    // Per-loop status vector indexed by the low code nibble
    for (genvar l = 0; l < LOOPS; l++) begin : g_loop
        logic [3:0] act_bits;
        for (genvar r = 0; r < 4; r++) begin : g_ref
            assign act_bits[r] = ref_status_i[8*r + ACTIVE_BASE_BIT + l];
        end
        always_comb begin
            loop_sig[l] = 16'h0000;
            loop_sig[l][SUB_PHASE_LOCK] = loop_lock_i[8*l + LOCK_PHASE_BIT];
            loop_sig[l][SUB_FREQ_LOCK] = loop_lock_i[8*l + LOCK_FREQ_BIT];
            loop_sig[l][SUB_ALOOP_LOCK] = loop_lock_i[8*l + ALOOP_LOCK_BIT];
            loop_sig[l][SUB_ALOOP_CAL] = loop_lock_i[8*l + ALOOP_CAL_BIT];
            loop_sig[l][SUB_ACTIVE] = |act_bits;
            loop_sig[l][SUB_FREE_RUN] = loop_state_i[8*l + FREE_RUN_BIT];
            loop_sig[l][SUB_HOLDOVER] = loop_state_i[8*l + HOLDOVER_BIT];
            loop_sig[l][SUB_SWITCH] = loop_state_i[8*l + SWITCH_BIT];
            loop_sig[l][SUB_HIST_AVAIL] = loop_hist_i[8*l + HIST_AVAIL_BIT];
            // Odd loops use the second event byte, even loops the first
            if (l % 2 == 1) begin
                loop_sig[l][SUB_HIST_UPD] = event_0f_i[HIST_EVT_BIT];
            end else begin
                loop_sig[l][SUB_HIST_UPD] = event_0c_i[HIST_EVT_BIT];
            end
            loop_sig[l][SUB_CLAMP] = loop_hist_i[8*l + CLAMP_BIT];
            loop_sig[l][SUB_SLEW] = loop_hist_i[8*l + SLEW_BIT];
            loop_sig[l][SUB_SYNC] = dist_sync_i[l];
            // Loop 2 keeps its odd bit position for the demap flag
            if (l == 2) begin
                loop_sig[l][SUB_DEMAP] = loop_hist_i[8*l + DEMAP_BIT_LOOP2];
            end else begin
                loop_sig[l][SUB_DEMAP] = loop_hist_i[8*l + DEMAP_BIT];
            end
        end
    end

    // Code decode; anything outside the loop groups stays low
    always_comb begin
        sel_nxt = 1'b0;
        if (func_r[DIR_BIT] && func_r[7:6] == LOOP_GROUP) begin
            sel_nxt = loop_sig[func_r[5:4]][func_r[3:0]];
        end
    end

    // Pin driver, one register stage from status to pin
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o <= sel_nxt;
            pin_oe_o <= func_r[DIR_BIT];
        end
    end

    // Input mode hand-off to the input function decoder
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            input_func_o <= 7'h00;
            input_level_o <= 1'b0;
        end else if (!func_r[DIR_BIT]) begin
            input_func_o <= func_r[6:0];
            input_level_o <= pin_i;
        end else begin
            input_func_o <= 7'h00;
            input_level_o <= 1'b0;
        end
    end

    // APB decode
    assign addr_ok = paddr_i == ADDR_FUNC || paddr_i == ADDR_PIN_STAT
        || paddr_i == ADDR_IRQ_STAT || paddr_i == ADDR_IRQ_MASK;
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i
        && addr_ok && pstrb_i[0];

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (paddr_i)
            ADDR_FUNC: begin
                rd_nxt[7:0] = func_r;
            end
            ADDR_PIN_STAT: begin
                rd_nxt[2:0] = {pin_oe_o, pin_o, input_level_o};
            end
            ADDR_IRQ_STAT: begin
                rd_nxt[IRQ_W-1:0] = irq_stat_r;
            end
            ADDR_IRQ_MASK: begin
                rd_nxt[IRQ_W-1:0] = irq_mask_r;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // One access cycle: ready in the cycle after setup
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !addr_ok;
            if (psel_i && !penable_i && !pwrite_i) begin
                prdata_o <= rd_nxt;
            end else if (pready_o) begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // Function code register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            func_r <= FUNC_RST;
        end else if (wr_en && paddr_i == ADDR_FUNC) begin
            func_r <= pwdata_i[7:0];
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_mask_r <= IRQ_MASK_RST;
        end else if (wr_en && paddr_i == ADDR_IRQ_MASK) begin
            irq_mask_r <= pwdata_i[IRQ_W-1:0];
        end
    end

    // Edge history for the pin events
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_d_r <= 1'b0;
            in_d_r <= 1'b0;
            lvl_vld_r <= 1'b0;
            prev_vld_r <= 1'b0;
        end else begin
            out_d_r <= pin_o;
            in_d_r <= input_level_o;
            // No false edge from the reset value or a mode change
            lvl_vld_r <= !func_r[DIR_BIT];
            prev_vld_r <= lvl_vld_r;
        end
    end

    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_OUT_RISE] = pin_oe_o && pin_o && !out_d_r;
        irq_evt[IRQ_OUT_FALL] = pin_oe_o && !pin_o && out_d_r;
        irq_evt[IRQ_IN_EDGE] = lvl_vld_r && prev_vld_r && (input_level_o != in_d_r);
    end

    assign irq_clr = (wr_en && paddr_i == ADDR_IRQ_STAT)
        ? pwdata_i[IRQ_W-1:0] : '0;

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_held_d5;
        (func_r == 8'hD5)[*2];
    endsequence

    sequence s_event_pending;
        (irq_stat_r & irq_mask_r) != '0;
    endsequence

    property p_input_mode;
        !func_r[DIR_BIT] |=> !pin_oe_o && !pin_o;
    endproperty
    a_input_mode: assert property (p_input_mode)
        else $error("pin driven while in input mode");

    property p_output_mode;
        func_r[DIR_BIT] |=> pin_oe_o;
    endproperty
    a_output_mode: assert property (p_output_mode)
        else $error("pin not driven in output mode");

    property p_phase_lock;
        func_r == 8'hD0 |=> pin_o == $past(loop_lock_i[8 + LOCK_PHASE_BIT]);
    endproperty
    a_phase_lock: assert property (p_phase_lock)
        else $error("loop 1 phase lock not on pin");

    property p_freq_lock;
        func_r == 8'hE1 |=> pin_o == $past(loop_lock_i[16 + LOCK_FREQ_BIT]);
    endproperty
    a_freq_lock: assert property (p_freq_lock)
        else $error("loop 2 frequency lock not on pin");

    property p_aloop_lock;
        func_r == 8'hF2 |=> pin_o == $past(loop_lock_i[24 + ALOOP_LOCK_BIT]);
    endproperty
    a_aloop_lock: assert property (p_aloop_lock)
        else $error("analog loop 3 lock not on pin");

    property p_aloop_cal;
        func_r == 8'hD3 |=> pin_o == $past(loop_lock_i[8 + ALOOP_CAL_BIT]);
    endproperty
    a_aloop_cal: assert property (p_aloop_cal)
        else $error("analog loop 1 calibration not on pin");

    property p_holdover;
        func_r == 8'hE6 |=> pin_o == $past(loop_state_i[16 + HOLDOVER_BIT]);
    endproperty
    a_holdover: assert property (p_holdover)
        else $error("loop 2 holdover not on pin");

    property p_switch;
        func_r == 8'hF7 |=> pin_o == $past(loop_state_i[24 + SWITCH_BIT]);
    endproperty
    a_switch: assert property (p_switch)
        else $error("loop 3 switchover not on pin");

    property p_hist_avail;
        func_r == 8'hE8 |=> pin_o == $past(loop_hist_i[16 + HIST_AVAIL_BIT]);
    endproperty
    a_hist_avail: assert property (p_hist_avail)
        else $error("loop 2 history available not on pin");

    property p_clamp;
        func_r == 8'hCA |=> pin_o == $past(loop_hist_i[CLAMP_BIT]);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("loop 0 clamp not on pin");

    property p_slew;
        func_r == 8'hDB |=> pin_o == $past(loop_hist_i[8 + SLEW_BIT]);
    endproperty
    a_slew: assert property (p_slew)
        else $error("loop 1 slew limit not on pin");

    property p_active;
        func_r == 8'hE4 |=> pin_o == $past(ref_status_i[6] || ref_status_i[14]
            || ref_status_i[22] || ref_status_i[30]);
    endproperty
    a_active: assert property (p_active)
        else $error("loop 2 active OR wrong");

    property p_free_run;
        s_held_d5 |-> pin_o == $past(loop_state_i[8 + FREE_RUN_BIT]);
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("loop 1 free run not on pin");

    property p_hist_upd;
        func_r == 8'hD9 |=> pin_o == $past(event_0f_i[HIST_EVT_BIT]);
    endproperty
    a_hist_upd: assert property (p_hist_upd)
        else $error("history update event not mirrored");

    property p_sync;
        func_r == 8'hFC |=> pin_o == $past(dist_sync_i[3]);
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync pulse not on pin");

    property p_demap;
        func_r == 8'hED |=> pin_o == $past(loop_hist_i[16 + DEMAP_BIT_LOOP2]);
    endproperty
    a_demap: assert property (p_demap)
        else $error("loop 2 demap flag wrong bit");

    property p_reserved;
        func_r == 8'hFE || func_r == 8'hFF || func_r == 8'hCF |=> !pin_o;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved code drives pin high");

    property p_latency;
        func_r == 8'hDA && $stable(func_r) && $changed(loop_hist_i[8 + CLAMP_BIT])
            |=> $changed(pin_o);
    endproperty
    a_latency: assert property (p_latency)
        else $error("pin did not follow status in one cycle");

    property p_irq;
        s_event_pending |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised for pending event");

endmodule

// ---- board_pin_model.sv ----
// Board-side model of the multifunction pin wire
`timescale 1ns/1ps
module board_pin_model (
    // Device side
    input wire logic drv_i,
    input wire logic oe_i,
    // Board side
    input wire logic board_drive_i,
    input wire logic board_level_i,
    // Resolved wire
    output logic pin_level_o
);
    // Pull-up on the board, so an undriven pin reads high
    assign pin_level_o = oe_i ? drv_i : (board_drive_i ? board_level_i : 1'h1);
endmodule

// ---- tb.sv ----
// Self-checking bench for the status pin selector
`timescale 1ns/1ps
module tb;
    import pin_mux_pkg::*;
    typedef struct {logic [7:0] code; int idx; logic [147:0] src;} row_t;
    logic clk_i = 0;
    logic resetn_i = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] strb = 4'hF;
    logic [147:0] stat = '0;
    logic board_drive = 0, board_level = 0;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, pin_o, pin_oe_o, pin_level, input_level_o, irq_o, err;
    logic [6:0] input_func_o;
    int errors = 0;
    int tests_run = 0;
    row_t rows[56];
    logic [7:0] rsvd[5] = '{8'hFE, 8'hFF, 8'hCE, 8'hDF, 8'hB0};

    always #2.5 clk_i = ~clk_i;

    status_pin_output_select DUT (
        .clk_i(clk_i), .resetn_i(resetn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(strb), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .ref_status_i(stat[147:116]), .loop_lock_i(stat[115:84]),
        .loop_state_i(stat[83:52]), .loop_hist_i(stat[51:20]),
        .event_0c_i(stat[19:12]), .event_0f_i(stat[11:4]), .dist_sync_i(stat[3:0]),
        .pin_i(pin_level), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .input_func_o(input_func_o), .input_level_o(input_level_o), .irq_o(irq_o)
    );

    board_pin_model partner (
        .drv_i(pin_o), .oe_i(pin_oe_o), .board_drive_i(board_drive),
        .board_level_i(board_level), .pin_level_o(pin_level)
    );

    task automatic stop_test();
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'h1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata_o;
        err = pslverr_o;
        psel <= 0;
        penable <= 0;
    endtask

    // Bit index into stat for loop l, sub code s
    function automatic int idx_of(int l, int s);
        case (s)
            0, 1, 2, 3: return 85 + 8 * l + s;
            4: return 120 + 9 * l;
            5, 6, 7: return 47 + 8 * l + s;
            8: return 20 + 8 * l;
            9: return (l % 2) ? 8 : 16;
            10, 11: return 11 + 8 * l + s;
            12: return l;
            default: return (l == 2) ? 40 : 23 + 8 * l;
        endcase
    endfunction

    // Every stat bit that feeds sub code s of loop l
    function automatic logic [147:0] src_of(int l, int s);
        logic [147:0] m;
        m = 148'h1 << idx_of(l, s);
        if (s == 4) begin
            for (int r = 0; r < 4; r++) begin
                m[120 + l + 8 * r] = 1'b1;
            end
        end
        return m;
    endfunction

    initial begin
        #50000;
        errors++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1;
        #1;
        chk("pin_oe_rst", pin_oe_o, 1'h0);
        chk("pin_rst", pin_o, 1'h0);
        apb(0, 12'h000, 32'h0000_0000);
        chk("func_rst", rd, 32'h0000_0000);
        for (int l = 0; l < 4; l++) begin
            for (int s = 0; s < 14; s++) begin
                rows[l * 14 + s].code = 8'hC0 + 8'(l * 16 + s);
                rows[l * 14 + s].idx = idx_of(l, s);
                rows[l * 14 + s].src = src_of(l, s);
            end
        end
        // One-hot then inverse: the pin must follow only its selected bit
        foreach (rows[i]) begin
            apb(1, 12'h000, {24'h00_0000, rows[i].code});
            stat <= 148'h1 << rows[i].idx;
            @(posedge clk_i);
            #1;
            chk("pin_hi", pin_o, 1'h1);
            chk("pin_oe", pin_oe_o, 1'h1);
            @(posedge clk_i);
            // Inverse clears every source of the code, all four for the OR
            stat <= ~rows[i].src;
            @(posedge clk_i);
            #1;
            chk("pin_lo", pin_o, 1'h0);
            chk("pin_oe_lo", pin_oe_o, 1'h1);
        end
        stat <= '1;
        foreach (rsvd[k]) begin
            apb(1, 12'h000, {24'h00_0000, rsvd[k]});
            repeat (2) @(posedge clk_i);
            #1;
            chk("pin_rsvd", pin_o, 1'h0);
            chk("oe_rsvd", pin_oe_o, 1'h1);
        end
        // Board drives low first, so the level is not the pull-up
        board_drive <= 1;
        board_level <= 0;
        apb(1, 12'h000, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        #1;
        chk("oe_in", pin_oe_o, 1'h0);
        chk("in_func", input_func_o, 7'h01);
        chk("in_level_lo", input_level_o, 1'h0);
        apb(1, 12'h008, 32'h0000_0007);
        board_level <= 1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("in_level", input_level_o, 1'h1);
        apb(0, 12'h004, 32'h0000_0000);
        chk("pin_stat", rd, 32'h0000_0001);
        apb(0, 12'h008, 32'h0000_0000);
        chk("irq_in_edge", rd, 32'h0000_0004);
        strb <= 4'h0;
        apb(1, 12'h000, 32'h0000_00D0);
        strb <= 4'hF;
        apb(0, 12'h000, 32'h0000_0000);
        chk("strb_ign", rd, 32'h0000_0001);
        apb(0, 12'h010, 32'h0000_0000);
        chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
        stat <= '0;
        apb(1, 12'h000, 32'h0000_00D0);
        repeat (3) @(posedge clk_i);
        apb(1, 12'h008, 32'h0000_0007);
        stat[93] <= 1;
        repeat (4) @(posedge clk_i);
        #1;
        chk("irq_masked", irq_o, 1'h0);
        apb(0, 12'h008, 32'h0000_0000);
        chk("irq_stat", rd, 32'h0000_0001);
        apb(1, 12'h00C, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        #1;
        chk("irq_on", irq_o, 1'h1);
        apb(1, 12'h008, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        #1;
        chk("irq_clr", irq_o, 1'h0);
        stat[93] <= 0;
        repeat (4) @(posedge clk_i);
        apb(0, 12'h008, 32'h0000_0000);
        chk("irq_fall", rd, 32'h0000_0002);
        // Reset in mid-run: pin, code and status back to idle
        @(posedge clk_i);
        resetn_i <= 0;
        @(posedge clk_i);
        #1;
        chk("oe_mid_rst", pin_oe_o, 1'h0);
        chk("irq_mid_rst", irq_o, 1'h0);
        @(posedge clk_i);
        resetn_i <= 1;
        repeat (3) @(posedge clk_i);
        apb(0, 12'h000, 32'h0000_0000);
        chk("func_mid_rst", rd, 32'h0000_0000);
        apb(0, 12'h008, 32'h0000_0000);
        chk("stat_mid_rst", rd, 32'h0000_0000);
        stop_test();
    end
endmodule
